// [verilog/amps_pkg.sv]
// constants for the amplifier mode and protection sequencer
// Function
// - three operating states chosen by mode select: standby, mute, on.
// - mute keeps both channels running but suppresses the audio.
// - on state runs both channels and passes audio.
// - leaving standby holds mute about 220 ms before mute or on; mute to on is immediate.
// - low temperature fault forces both enables low immediately, no clock.
// - temperature fault release raises enables immediately, no added delay.
// - fault inputs idle high by pull-up; open-drain lines wire-OR.
// - two fault inputs, temperature and overcurrent, shared by stages.
// - one stage enable output per channel.
// - DC level on oscillator pin selects external carrier, internal off.
// - internal carrier runs at about 300 kHz.
// - overcurrent forces enables low at once; retry every 220 ms.
// - standby-to-mute checks outputs for shorts; start-up halts until clear.
package amps_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned DWELL_MS      = 220;
  localparam int unsigned RETRY_MS      = 220;
  localparam int unsigned CARRIER_HZ    = 300_000;
  localparam longint unsigned DWELL_CYC = longint'(CLK_HZ) * DWELL_MS / 1000;
  localparam longint unsigned RETRY_CYC = longint'(CLK_HZ) * RETRY_MS / 1000;
  localparam int unsigned CARRIER_DIV   = CLK_HZ / CARRIER_HZ;
  localparam int unsigned CNT_W         = 26;
  localparam int unsigned DIV_W         = 10;
  // mode select encodings
  localparam logic [1:0] MODE_STANDBY   = 2'h0;
  localparam logic [1:0] MODE_MUTE      = 2'h1;
  localparam logic [1:0] MODE_ON        = 2'h2;
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_CHECK,
    ST_DWELL,
    ST_MUTE,
    ST_ON
  } amps_state_e;
endpackage

// [verilog/amps_carrier_div.sv]
// carrier enable divider for the internal oscillator
`timescale 1ns/1ns
module amps_carrier_div #(
  parameter int unsigned DIV = amps_pkg::CARRIER_DIV
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // control
  input  wire logic run,
  // output
  output logic      tick
);
  logic [amps_pkg::DIV_W-1:0] cnt;
  logic [amps_pkg::DIV_W-1:0] next_cnt;
  logic                       next_tick;

  // free count, one pulse per carrier period
  always_comb
  begin
    next_cnt  = cnt + 1'b1;
    next_tick = 1'b0;
    if (!run)
    begin
      next_cnt = '0;
    end
    else if (cnt == amps_pkg::DIV_W'(DIV - 1))
    begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// [verilog/amps_sequencer.sv]
// mode sequencing and fault protection for a two-channel class-d controller
`timescale 1ns/1ns
module amps_sequencer #(
  parameter longint unsigned DWELL_CYC = amps_pkg::DWELL_CYC,
  parameter longint unsigned RETRY_CYC = amps_pkg::RETRY_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // mode select, from comparators off the pin
  input  wire logic [1:0] mode_sel,
  // fault lines from the power stages, active low
  input  wire logic       temperature_fault_in_n,
  input  wire logic       overcurrent_fault_in_n,
  // start-up short check result from feedback comparators
  input  wire logic       output_short_in,
  // oscillator pin: dc level above ground and external carrier edges
  input  wire logic       osc_dc_high,
  input  wire logic       osc_ext_in,
  // stage enables
  output logic            channel_a_stage_enable,
  output logic            channel_b_stage_enable,
  // status to the modulator
  output logic            modulator_run,
  output logic            audio_pass,
  output logic            carrier_tick,
  output logic            ext_carrier_sel
);
  // mode select synchroniser, standby while in reset
  logic [1:0] mode_s1;
  logic [1:0] mode_s2;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_s1 <= amps_pkg::MODE_STANDBY;
      mode_s2 <= amps_pkg::MODE_STANDBY;
    end
    else
    begin
      mode_s1 <= mode_sel;
      mode_s2 <= mode_s1;
    end
  end

  // overcurrent synchroniser; resets to the pulled-up idle level so
  // no false trip follows reset
  logic       cur_s1;
  logic       cur_s2;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_s1 <= 1'b1;
      cur_s2 <= 1'b1;
    end
    else
    begin
      cur_s1 <= overcurrent_fault_in_n;
      cur_s2 <= cur_s1;
    end
  end

  // start-up short detector synchroniser
  logic       sh_s1;
  logic       sh_s2;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_s1 <= 1'b0;
      sh_s2 <= 1'b0;
    end
    else
    begin
      sh_s1 <= output_short_in;
      sh_s2 <= sh_s1;
    end
  end

  // oscillator pin synchronisers; ext_d is one stage more for the edge
  logic       dc_s1;
  logic       dc_s2;
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_d;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dc_s1  <= 1'b0;
      dc_s2  <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_d  <= 1'b0;
    end
    else
    begin
      dc_s1  <= osc_dc_high;
      dc_s2  <= dc_s1;
      ext_s1 <= osc_ext_in;
      ext_s2 <= ext_s1;
      ext_d  <= ext_s2;
    end
  end

  // carrier source: internal divider off while external selected
  logic int_tick;
  amps_carrier_div #(
    .DIV (amps_pkg::CARRIER_DIV)
  ) u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .run      (!dc_s2),
    .tick     (int_tick)
  );

  // sequencer state
  amps_pkg::amps_state_e     state, next_state;
  logic [amps_pkg::CNT_W-1:0] dwell, next_dwell;
  logic [amps_pkg::CNT_W-1:0] retry, next_retry;
  logic                       cur_trip, next_cur_trip;
  logic                       en_q, next_en_q;
  logic                       tick_q, next_tick_q;

  // next state: mode request, dwell and short check
  always_comb
  begin
    next_state = state;
    next_dwell = dwell;
    case (state)
      amps_pkg::ST_STANDBY:
      begin
        if (mode_s2 != amps_pkg::MODE_STANDBY)
        begin
          next_state = amps_pkg::ST_CHECK;
        end
      end
      amps_pkg::ST_CHECK:
      begin
        if (mode_s2 == amps_pkg::MODE_STANDBY)
        begin
          next_state = amps_pkg::ST_STANDBY;
        end
        else if (!sh_s2)
        begin
          next_state = amps_pkg::ST_DWELL;
          next_dwell = '0;
        end
      end
      amps_pkg::ST_DWELL:
      begin
        if (mode_s2 == amps_pkg::MODE_STANDBY)
        begin
          next_state = amps_pkg::ST_STANDBY;
        end
        else if (dwell == amps_pkg::CNT_W'(DWELL_CYC - 1))
        begin
          next_state = (mode_s2 == amps_pkg::MODE_ON) ? amps_pkg::ST_ON
                                                      : amps_pkg::ST_MUTE;
        end
        else
        begin
          next_dwell = dwell + 1'b1;
        end
      end
      amps_pkg::ST_MUTE:
      begin
        if (mode_s2 == amps_pkg::MODE_STANDBY)
        begin
          next_state = amps_pkg::ST_STANDBY;
        end
        else if (mode_s2 == amps_pkg::MODE_ON)
        begin
          next_state = amps_pkg::ST_ON;
        end
      end
      amps_pkg::ST_ON:
      begin
        // leaving on is immediate, no dwell
        if (mode_s2 == amps_pkg::MODE_STANDBY)
        begin
          next_state = amps_pkg::ST_STANDBY;
        end
        else if (mode_s2 != amps_pkg::MODE_ON) // unused code 3 counts as mute
        begin
          next_state = amps_pkg::ST_MUTE;
        end
      end
      default:
      begin
        next_state = amps_pkg::ST_STANDBY;
      end
    endcase
  end

  // state and dwell registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= amps_pkg::ST_STANDBY;
      dwell <= '0;
    end
    else
    begin
      state <= next_state;
      dwell <= next_dwell;
    end
  end

  // overcurrent trip and retry timer; a trip is only taken while the
  // stages are enabled, so a stuck line cannot lock out start-up
  always_comb
  begin
    next_cur_trip = cur_trip;
    next_retry    = retry;
    if (state == amps_pkg::ST_STANDBY || next_state == amps_pkg::ST_STANDBY)
    begin
      // standby forgets any trip and ignores the fault lines
      next_cur_trip = 1'b0;
      next_retry    = '0;
    end
    else if (cur_trip)
    begin
      if (retry == amps_pkg::CNT_W'(RETRY_CYC - 1))
      begin
        next_cur_trip = 1'b0;
        next_retry    = '0;
      end
      else
      begin
        next_retry = retry + 1'b1;
      end
    end
    else if (!cur_s2 && en_q)
    begin
      next_cur_trip = 1'b1;
      next_retry    = '0;
    end
  end

  // trip and retry registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_trip <= 1'b0;
      retry    <= '0;
    end
    else
    begin
      cur_trip <= next_cur_trip;
      retry    <= next_retry;
    end
  end

  // stage enable and carrier pulse
  always_comb
  begin
    // stages run in dwell, mute and on once the start-up check has passed
    next_en_q   = (next_state == amps_pkg::ST_MUTE || next_state == amps_pkg::ST_ON
                   || next_state == amps_pkg::ST_DWELL) && !next_cur_trip;
    // external edges count only while the dc level selects them
    next_tick_q = dc_s2 ? (ext_s2 && !ext_d) : int_tick;
  end

  // enable and pulse registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en_q   <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      en_q   <= next_en_q;
      tick_q <= next_tick_q;
    end
  end

  // fault gating is combinational so a low line cuts the enables with no
  // clock edge; the temperature line needs no synchroniser on this path.
  // the raw overcurrent line also gates so the cut is immediate, the
  // synchronised copy starts the retry timer.
  // no hysteresis here, the power stage owns it
  logic [1:0] stage_en;
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_stage
    assign stage_en[ch] = en_q && temperature_fault_in_n
                          && overcurrent_fault_in_n;
  end
  assign channel_a_stage_enable = stage_en[0];
  assign channel_b_stage_enable = stage_en[1];

  // modulator status
  assign modulator_run   = en_q;
  assign audio_pass      = en_q && (state == amps_pkg::ST_ON);
  assign carrier_tick    = tick_q;
  assign ext_carrier_sel = dc_s2;
endmodule

// [bench/amps_sequencer_assertions.sv]
// checker for the mode and protection sequencer
`timescale 1ns/1ns
module amps_checker #(
  parameter longint unsigned DWELL_CYC = 50
) (
  // clock, reset and inputs
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [1:0] mode_sel,
  input wire logic       temperature_fault_in_n,
  input wire logic       overcurrent_fault_in_n,
  input wire logic       output_short_in,
  input wire logic       osc_dc_high,
  // outputs
  input wire logic       channel_a_stage_enable,
  input wire logic       channel_b_stage_enable,
  input wire logic       modulator_run,
  input wire logic       audio_pass,
  input wire logic       carrier_tick,
  input wire logic       ext_carrier_sel
);
  longint unsigned run_cnt;
  // run length, so a short dwell shows up
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      run_cnt <= 0;
    else
      run_cnt <= modulator_run ? run_cnt + 1 : 0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_temp_gate: assert property (!temperature_fault_in_n |->
    !channel_a_stage_enable && !channel_b_stage_enable) else $error("temp gate");
  chk_cur_gate: assert property (!overcurrent_fault_in_n |->
    !channel_a_stage_enable && !channel_b_stage_enable) else $error("cur gate");
  chk_standby_off: assert property ((mode_sel == 2'h0)[*5] |->
    !modulator_run && !channel_a_stage_enable) else $error("standby run");
  chk_audio_run: assert property (audio_pass |->
    modulator_run && $past(mode_sel, 3) == 2'h2) else $error("audio in mute");
  chk_on_leave: assert property (audio_pass && mode_sel != 2'h2 |->
    ##[1:3] !audio_pass) else $error("slow leave");
  chk_dwell_len: assert property ($rose(audio_pass) |->
    run_cnt == 0 || run_cnt >= DWELL_CYC - 1) else $error("short dwell");
  chk_ext_sel: assert property (osc_dc_high[*4] |-> ext_carrier_sel)
    else $error("ext select");
  chk_tick_pulse: assert property (carrier_tick |=> !carrier_tick)
    else $error("tick width");
  chk_tick_alive: assert property (carrier_tick && !ext_carrier_sel |->
    ##[1:833] (carrier_tick || ext_carrier_sel)) else $error("tick lost");
  chk_short_hold: assert property ((output_short_in && !modulator_run)[*4]
    |=> !modulator_run) else $error("short ignored");
  cover property ($rose(audio_pass));
  cover property ($fell(modulator_run) && !overcurrent_fault_in_n);
  cover property ($rose(ext_carrier_sel));
endmodule
bind amps_sequencer amps_checker #(.DWELL_CYC(DWELL_CYC)) chk (
  .core_clk, .nrst, .mode_sel, .temperature_fault_in_n,
  .overcurrent_fault_in_n, .output_short_in, .osc_dc_high,
  .channel_a_stage_enable, .channel_b_stage_enable, .modulator_run,
  .audio_pass, .carrier_tick, .ext_carrier_sel);

// [bench/amps_stage_model.sv]
// power stage model driving the open-drain fault lines
`timescale 1ns/1ns
module amps_stage_model #(
  parameter int HYS = 6
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // conditions and enables
  input  wire logic hot,
  input  wire logic shorted,
  input  wire logic en_a,
  input  wire logic en_b,
  // fault lines, pulled up
  output wire logic temp_n,
  output wire logic cur_n
);
  int   cool;
  logic trip;
  // hysteresis sits here, the controller adds none
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      cool <= 0;
      trip <= 1'b0;
    end
    else
    begin
      cool <= hot ? HYS : (cool > 0 ? cool - 1 : 0);
      trip <= shorted && (en_a || en_b || trip);
    end
  // open drain: low while faulted, else pull-up
  assign temp_n = (hot || cool > 0) ? 1'b0 : 1'b1;
  assign cur_n  = trip ? 1'b0 : 1'b1;
endmodule

// [bench/tb.sv]
// self-checking bench for the mode and protection sequencer
`timescale 1ns/1ns
module tb;
  localparam int DW = 50;
  localparam int RT = 50;
  localparam int HY = 6;
  localparam int SPAN = 2 * amps_pkg::CARRIER_DIV;
  logic       core_clk = 1'b0;
  logic       nrst     = 1'b0;
  logic [1:0] mode_sel = amps_pkg::MODE_STANDBY;
  logic       short_in = 1'b0;
  logic       dc_hi    = 1'b0;
  logic       ext_in   = 1'b0;
  logic       hot      = 1'b0;
  logic       shorted  = 1'b0;
  logic [7:0] rnd      = 8'h0f;
  logic       en_a, en_b, run, audio, tick, ext_sel;
  wire        temp_n, cur_n;
  int         fail_count, n_compared, n, ticks, cycles;
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  amps_sequencer #(.DWELL_CYC(DW), .RETRY_CYC(RT)) uut (
    .core_clk, .nrst, .mode_sel,
    .temperature_fault_in_n(temp_n), .overcurrent_fault_in_n(cur_n),
    .output_short_in(short_in), .osc_dc_high(dc_hi), .osc_ext_in(ext_in),
    .channel_a_stage_enable(en_a), .channel_b_stage_enable(en_b),
    .modulator_run(run), .audio_pass(audio), .carrier_tick(tick),
    .ext_carrier_sel(ext_sel));
  amps_stage_model #(.HYS(HY)) stage (
    .core_clk, .nrst, .hot, .shorted, .en_a, .en_b, .temp_n, .cur_n);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // internal carrier pulses expected over a span of cycles
  function automatic int exp_ticks(input int span);
    return span / amps_pkg::CARRIER_DIV;
  endfunction
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: bit %b", $time, got);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("mismatch at %0t: count %0d", $time, got);
    end
  endtask
  // falling-edge steps; ticks are tallied on the way
  task automatic cyc(input int k);
    repeat (k)
    begin
      @(negedge core_clk);
      ticks += (tick === 1'b1);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 400)
    begin
      cyc(1);
      n++;
    end
  endtask
  initial
  begin
    cyc(5);
    nrst = 1'b1;
    hot = 1'b1;
    shorted = 1'b1;
    cyc(8);
    chk_bit(en_a | en_b | run | audio, 1'b0);
    hot = 1'b0;
    shorted = 1'b0;
    short_in = 1'b1;
    mode_sel = amps_pkg::MODE_MUTE;
    cyc(HY + 20);
    chk_bit(run, 1'b0);
    short_in = 1'b0;
    wait_for(run, 1'b1);
    chk_n(n, 1, 6);
    chk_bit(en_a & en_b, 1'b1);
    cyc(DW + 4);
    chk_bit(audio, 1'b0);
    mode_sel = amps_pkg::MODE_ON;
    cyc(4);
    chk_bit(audio & en_b, 1'b1);
    mode_sel = amps_pkg::MODE_STANDBY;
    cyc(4);
    chk_bit(run | en_a, 1'b0);
    mode_sel = amps_pkg::MODE_ON;
    wait_for(run, 1'b1);
    wait_for(audio, 1'b1);
    chk_n(n, DW - 1, DW + 1);
    mode_sel = 2'h3;
    cyc(4);
    chk_bit(run & ~audio, 1'b1);
    mode_sel = amps_pkg::MODE_ON;
    cyc(4);
    chk_bit(audio, 1'b1);
    $display("test modes done");
    // random fault lengths
    repeat (3)
    begin
      rnd = lfsr(rnd);
      hot = 1'b1;
      #1 chk_bit(en_a | en_b, 1'b0);
      cyc(1 + rnd[2:0]);
      hot = 1'b0;
      wait_for(en_a, 1'b1);
      chk_n(n, HY, HY);
    end
    shorted = 1'b1;
    cyc(1);
    chk_bit(en_a | en_b, 1'b0);
    wait_for(run, 1'b0);
    wait_for(run, 1'b1);
    chk_n(n, RT - 1, RT + 1);
    chk_bit(en_a, 1'b0);
    wait_for(run, 1'b0);
    chk_n(n, 1, 6);
    shorted = 1'b0;
    wait_for(en_a, 1'b1);
    chk_n(n, RT - 1, RT + 1);
    chk_bit(audio, 1'b1);
    $display("test faults done");
    ticks = 0;
    cyc(SPAN);
    chk_n(ticks, exp_ticks(SPAN), exp_ticks(SPAN));
    dc_hi = 1'b1;
    cyc(4);
    chk_bit(ext_sel, 1'b1);
    ticks = 0;
    repeat (8)
    begin
      rnd = lfsr(rnd);
      ext_in = 1'b1;
      cyc(3 + rnd[1:0]);
      ext_in = 1'b0;
      cyc(3 + rnd[3:2]);
    end
    cyc(6);
    chk_n(ticks, 8, 8);
    $display("test carrier done");
    give_verdict();
  end
  // hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end
endmodule
